// [src/cslt_defs.vh]
// Constants for the cascade single-line transceiver.
// Assumes inclusion by bare name from the design files; definitions only.
// Behaviour
// RQ1: High count at most threshold minus 2 decodes as zero.
// RQ2: High count at least threshold plus 1 decodes as one.
// RQ3: Each rising edge starts a high count, judged at the falling edge.
// RQ4: Input constant until reset timeout expires sets the line reset flag.
// RQ5: While line reset is set, the bypass path is off.
// RQ6: Line reset clears full, timeout and bypass flags, sets receive enable.
// RQ7: After 24xN bits: frame full, bypass on, receive off, interrupt raised.
// RQ8: With bypass on, serial input drives serial output.
// RQ9: First rising edge after a line reset clears the line reset flag.
// RQ10: Bits before the last time out without a next rising edge.
// RQ11: Last bit falling edge before period expiry sets both full flags.
// RQ12: Last bit falling edge before threshold expiry gives a zero.
// RQ13: Threshold expiry on last bit stores a one, done at falling edge.
// RQ14: Last bit stuck high to period expiry: timeout, fulls cleared.
// RQ15: Clearing transceiver enable stops receive and transmit.
// RQ16: Transmit mode with bypass off routes transmitter to the output.
// RQ17: Trigger shifts out the three transmit bytes, 24 bits.
// RQ18: Controller reloads the three bytes before triggering again.
// RQ19: Transmitter can issue a line reset after a whole cascade frame.
// RQ20: Hardware clears the trigger when transmit empty sets.
// RQ21: All counts run from the selectable cascade clock enable.
// RQ22: Frame length codes 0 to 10 give N 1 to 11, others 12.
// RQ23: Each event raises the interrupt only when its enable is set.
// RQ24: Word full sets every 24 bits and only software clears it; the code also clears it on line reset and on a high-phase timeout of any bit.
// RQ25: Trigger clears transmit empty; it sets after all 24 bits.
// RQ26: Transmit ones as long pulses, zeros as short, MSB first.
// RQ27: Shift bits in arrival order; ignore input while timed out.
`ifndef CSLT_DEFS_VH
`define CSLT_DEFS_VH
`define CSLT_WORD_BITS 24
`define CSLT_CNT_W 8
`define CSLT_BITCNT_W 9
`define CSLT_ZERO_MARGIN 8'h02
`define CSLT_ONE_MARGIN 8'h01
`define CSLT_N_MAX_CODE 4'ha
`define CSLT_N_MAX 4'hc
`define CSLT_FRAME_LEN_RESET 4'h3
`define CSLT_BUF_DEPTH 2
`endif

// [src/cslt_buf.v]
// Two-entry valid/ready buffer for received 24-bit words.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module cslt_buf #(
    parameter WIDTH = 24
) (
    input wire mclk,
    input wire reset_n,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem0;
    reg [WIDTH-1:0] mem1;
    reg [1:0] count;
    wire push;
    wire pop;

    // Entry 0 is always the head, so the output needs no read mux.
    assign in_ready = (count != 2'd2);
    assign out_valid = (count != 2'd0);
    assign out_data = mem0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Shift on pop; write lands behind whatever remains.
    always @(posedge mclk) begin
        if (!reset_n || flush) begin
            count <= 2'd0;
        end else begin
            if (pop) begin
                mem0 <= mem1;
            end
            if (push) begin
                if (count == 2'd0 || (count == 2'd1 && pop)) begin
                    mem0 <= in_data;
                end else begin
                    mem1 <= in_data;
                end
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// [src/cslt_top.v]
// Cascade single-line pulse-width transceiver, receive and transmit.
// Assumes all inputs synchronous to mclk; the control bits are plain ports.
`timescale 1ns/100ps
`include "cslt_defs.vh"
module cslt_top #(
    parameter CLK_DIV = 8'd4,
    parameter RESET_TIMEOUT = 16'd200,
    parameter BIT_PERIOD = 8'd20
) (
    input wire mclk,
    input wire reset_n,
    input wire cascade_serial_in,
    output reg cascade_serial_out,
    input wire transceiver_enable,
    input wire transmit_mode_select,
    input wire [3:0] frame_length_select,
    input wire [7:0] high_threshold_count,
    input wire [7:0] cascade_clock_div,
    input wire [7:0] bit_period_count,
    input wire [15:0] reset_timeout_count,
    input wire [7:0] transmit_data_byte0,
    input wire [7:0] transmit_data_byte1,
    input wire [7:0] transmit_data_byte2,
    input wire transmit_trigger_set,
    input wire word_full_clear,
    input wire bypass_clear,
    input wire line_reset_send,
    input wire [4:0] int_enable,
    output reg transmit_trigger,
    output reg transmit_empty_flag,
    output reg line_reset_flag,
    output reg frame_full_flag,
    output reg word_full_flag,
    output reg bit_timeout_flag,
    output reg bypass_enable,
    output reg receive_enable,
    output reg cascade_interrupt,
    output reg rx_word_valid,
    input wire rx_word_ready,
    output reg [23:0] rx_word
);
    localparam ST_IDLE = 3'b001;
    localparam ST_HIGH = 3'b010;
    localparam ST_LOW = 3'b100;

    // Frame length code to N, used in one place, for frame_bits.
    function [3:0] frame_n;
        input [3:0] code;
        begin
            if (code > `CSLT_N_MAX_CODE) begin
                frame_n = `CSLT_N_MAX;
            end else begin
                frame_n = code + 4'h1;
            end
        end
    endfunction

    reg [7:0] div_cnt;
    reg tick;
    reg din_q;
    reg [2:0] rx_state;
    reg [7:0] high_cnt;
    reg [7:0] period_cnt;
    reg [15:0] rst_cnt;
    reg [8:0] bit_idx;
    reg [23:0] rx_shift;
    reg [4:0] word_bits;
    reg push_valid;
    reg [23:0] push_data;
    reg [23:0] tx_shift;
    reg [4:0] tx_bits;
    reg [7:0] tx_cnt;
    reg tx_high;
    reg tx_busy;
    reg [15:0] tx_rst_cnt;
    wire rise;
    wire fall;
    wire last_bit;
    wire is_one;
    wire is_zero;
    wire buf_in_ready;
    wire buf_out_valid;
    wire [23:0] buf_out_data;
    wire [8:0] frame_bits;
    wire tx_path;

    assign rise = cascade_serial_in && !din_q;   // see RQ3
    assign fall = !cascade_serial_in && din_q;
    assign frame_bits = frame_n(frame_length_select) * 9'd24;  // see RQ22
    assign last_bit = (bit_idx == frame_bits - 9'd1);
    assign is_one = (high_cnt >= high_threshold_count
        + `CSLT_ONE_MARGIN);                     // see RQ2
    assign is_zero = (high_cnt + `CSLT_ZERO_MARGIN
        <= high_threshold_count);                // see RQ1
    assign tx_path = transmit_mode_select && !bypass_enable;  // see RQ16

    // Cascade clock enable; a zero divisor means every mclk cycle.
    always @(posedge mclk) begin
        if (!reset_n) begin
            div_cnt <= 8'h00;
            tick <= 1'b0;
        end else if (div_cnt >= cascade_clock_div) begin
            div_cnt <= 8'h00;
            tick <= 1'b1;                        // see RQ21
        end else begin
            div_cnt <= div_cnt + 8'h01;
            tick <= 1'b0;
        end
    end

    // Receive decoder, line reset detection and flag maintenance.
    always @(posedge mclk) begin
        if (!reset_n) begin
            din_q <= 1'b0;
            rx_state <= ST_IDLE;
            high_cnt <= 8'h00;
            period_cnt <= 8'h00;
            rst_cnt <= reset_timeout_count;
            bit_idx <= 9'h000;
            rx_shift <= 24'h000000;
            word_bits <= 5'h00;
            push_valid <= 1'b0;
            push_data <= 24'h000000;
            line_reset_flag <= 1'b0;
            frame_full_flag <= 1'b0;
            word_full_flag <= 1'b0;
            bit_timeout_flag <= 1'b0;
            bypass_enable <= 1'b0;
            receive_enable <= 1'b1;
        end else begin
            din_q <= cascade_serial_in;
            if (push_valid && buf_in_ready) begin
                push_valid <= 1'b0;
            end
            if (bypass_clear) begin
                bypass_enable <= 1'b0;
            end
            if (word_full_clear) begin
                word_full_flag <= 1'b0;          // see RQ24
            end
            // Idle-line timer restarts on any edge.
            if (rise || fall || !transceiver_enable || tx_path) begin
                rst_cnt <= reset_timeout_count;
            end else if (tick && rst_cnt != 16'h0000) begin
                rst_cnt <= rst_cnt - 16'h0001;
            end
            if (!transceiver_enable || tx_path) begin
                rx_state <= ST_IDLE;             // see RQ15
            end else if (rst_cnt == 16'h0000 && !line_reset_flag) begin
                line_reset_flag <= 1'b1;         // see RQ4
                frame_full_flag <= 1'b0;         // see RQ6
                word_full_flag <= 1'b0;
                bit_timeout_flag <= 1'b0;
                bypass_enable <= 1'b0;
                receive_enable <= 1'b1;
                rx_state <= ST_IDLE;
                bit_idx <= 9'h000;
                word_bits <= 5'h00;
                rst_cnt <= reset_timeout_count;
            end else if (receive_enable && !bit_timeout_flag) begin
                // Decoding is frozen while timed out.   see RQ27
                if (rise) begin
                    line_reset_flag <= 1'b0;     // see RQ9
                    rx_state <= ST_HIGH;
                    high_cnt <= 8'h00;
                    period_cnt <= bit_period_count;
                end else case (rx_state)
                    ST_IDLE: begin
                    end
                    ST_HIGH: begin
                        if (tick) begin
                            high_cnt <= high_cnt + 8'h01;
                            period_cnt <= period_cnt - 8'h01;
                        end
                        if (tick && period_cnt == 8'h00) begin
                            bit_timeout_flag <= 1'b1;  // see RQ10 RQ14
                            frame_full_flag <= 1'b0;
                            word_full_flag <= 1'b0;
                            rx_state <= ST_IDLE;
                        end else if (fall) begin
                            // Ambiguous widths keep the threshold side.
                            rx_shift <= {rx_shift[22:0],
                                is_one || !is_zero};   // see RQ12 RQ13
                            bit_idx <= bit_idx + 9'h001;
                            if (word_bits == 5'd23) begin
                                word_bits <= 5'h00;
                                word_full_flag <= 1'b1;
                                push_valid <= 1'b1;
                                push_data <= {rx_shift[22:0],
                                    is_one || !is_zero};
                            end else begin
                                word_bits <= word_bits + 5'h01;
                            end
                            if (last_bit) begin
                                frame_full_flag <= 1'b1;  // see RQ7 RQ11
                                word_full_flag <= 1'b1;
                                bypass_enable <= 1'b1;
                                receive_enable <= 1'b0;
                                rx_state <= ST_IDLE;
                            end else begin
                                rx_state <= ST_LOW;
                            end
                        end
                    end
                    ST_LOW: begin
                        if (tick) begin
                            period_cnt <= period_cnt - 8'h01;
                        end
                        if (tick && period_cnt == 8'h00) begin
                            bit_timeout_flag <= 1'b1;  // see RQ10
                            rx_state <= ST_IDLE;
                        end
                    end
                    default: rx_state <= ST_IDLE;
                endcase
            end
        end
    end

    // Transmitter: trigger loads three bytes, MSB first.
    always @(posedge mclk) begin
        if (!reset_n) begin
            transmit_trigger <= 1'b0;
            transmit_empty_flag <= 1'b1;
            tx_shift <= 24'h000000;
            tx_bits <= 5'h00;
            tx_cnt <= 8'h00;
            tx_high <= 1'b0;
            tx_busy <= 1'b0;
            tx_rst_cnt <= 16'h0000;
        end else if (!transceiver_enable || !tx_path) begin
            transmit_trigger <= 1'b0;            // see RQ15
            tx_busy <= 1'b0;
            tx_high <= 1'b0;
            tx_rst_cnt <= 16'h0000;
        end else if (transmit_trigger_set && !tx_busy) begin
            transmit_trigger <= 1'b1;            // see RQ17
            transmit_empty_flag <= 1'b0;         // see RQ25
            tx_shift <= {transmit_data_byte0, transmit_data_byte1,
                transmit_data_byte2};            // see RQ18
            tx_bits <= 5'h00;
            tx_busy <= 1'b1;
            tx_high <= 1'b0;
            tx_cnt <= 8'h00;
        end else if (line_reset_send && !tx_busy) begin
            // Hold the line low past the receiver's timeout.  see RQ19
            tx_rst_cnt <= reset_timeout_count + 16'h0002;
        end else if (tx_rst_cnt != 16'h0000) begin
            if (tick) begin
                tx_rst_cnt <= tx_rst_cnt - 16'h0001;
            end
        end else if (tx_busy && tick) begin
            if (tx_cnt != 8'h00) begin
                tx_cnt <= tx_cnt - 8'h01;
            end else if (!tx_high) begin
                tx_high <= 1'b1;                 // see RQ26
                tx_cnt <= tx_shift[23] ?
                    high_threshold_count + 8'h02 :
                    high_threshold_count - 8'h03;
            end else begin
                tx_high <= 1'b0;
                tx_shift <= {tx_shift[22:0], 1'b0};
                if (tx_bits == 5'd23) begin
                    tx_busy <= 1'b0;
                    transmit_empty_flag <= 1'b1;  // see RQ25
                    transmit_trigger <= 1'b0;     // see RQ20
                end else begin
                    tx_bits <= tx_bits + 5'h01;
                    tx_cnt <= bit_period_count - high_threshold_count;
                end
            end
        end
    end

    // Output mux and gated interrupt, both registered.
    always @(posedge mclk) begin
        if (!reset_n) begin
            cascade_serial_out <= 1'b0;
            cascade_interrupt <= 1'b0;
            rx_word_valid <= 1'b0;
            rx_word <= 24'h000000;
        end else begin
            if (tx_path && transceiver_enable) begin
                cascade_serial_out <= tx_high;
            end else if (bypass_enable && !line_reset_flag) begin
                cascade_serial_out <= cascade_serial_in;  // see RQ5 RQ8
            end else begin
                cascade_serial_out <= 1'b0;
            end
            cascade_interrupt <= (int_enable[0] && frame_full_flag)
                || (int_enable[1] && transmit_empty_flag)
                || (int_enable[2] && line_reset_flag)
                || (int_enable[3] && bit_timeout_flag)
                || (int_enable[4] && word_full_flag);  // see RQ23
            rx_word_valid <= buf_out_valid && !(rx_word_valid
                && rx_word_ready);
            rx_word <= buf_out_data;
        end
    end

    cslt_buf #(.WIDTH(`CSLT_WORD_BITS)) u_buf (
        .mclk(mclk),
        .reset_n(reset_n),
        .flush(1'b0),
        .in_valid(push_valid),
        .in_ready(buf_in_ready),
        .in_data(push_data),
        .out_valid(buf_out_valid),
        .out_ready(rx_word_valid && rx_word_ready),
        .out_data(buf_out_data)
    );
endmodule

// [dv/cslt_top_properties.sv]
// Concurrent checks on the transceiver top's ports.
// Assumes mclk and synchronous active-low reset_n.
`timescale 1ns/100ps
module cslt_top_checker (
    input wire mclk,
    input wire reset_n,
    input wire cascade_serial_in,
    input wire cascade_serial_out,
    input wire transceiver_enable,
    input wire [4:0] int_enable,
    input wire transmit_trigger,
    input wire transmit_empty_flag,
    input wire line_reset_flag,
    input wire frame_full_flag,
    input wire word_full_flag,
    input wire bit_timeout_flag,
    input wire bypass_enable,
    input wire receive_enable,
    input wire cascade_interrupt
);
    // Enabled events; the interrupt trails by one register.
    wire any_event;
    assign any_event = |(int_enable & {word_full_flag, bit_timeout_flag,
        line_reset_flag, transmit_empty_flag, frame_full_flag});
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_reset_entry;
        $rose(line_reset_flag);
    endsequence
    sequence s_first_rise;
        line_reset_flag && $rose(cascade_serial_in);
    endsequence
    property p_reset_clears;
        s_reset_entry |-> !frame_full_flag && !word_full_flag &&
            !bit_timeout_flag && !bypass_enable && receive_enable;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("line reset left a flag wrong");
    property p_no_bypass;
        line_reset_flag |-> !bypass_enable;
    endproperty
    a_no_bypass: assert property (p_no_bypass)
        else $error("bypass on during line reset");
    property p_frame_done;
        $rose(frame_full_flag) |-> ##[0:1] bypass_enable && !receive_enable;
    endproperty
    a_frame_done: assert property (p_frame_done)
        else $error("frame full without bypass");
    property p_copy;
        bypass_enable && $past(bypass_enable) && transceiver_enable &&
            $past(transceiver_enable) |->
            cascade_serial_out == $past(cascade_serial_in);
    endproperty
    a_copy: assert property (p_copy)
        else $error("bypass output not a copy");
    property p_rise_clears;
        s_first_rise |-> ##[1:2] !line_reset_flag;
    endproperty
    a_rise_clears: assert property (p_rise_clears)
        else $error("rise left line reset set");
    property p_empty_drops_trig;
        $rose(transmit_empty_flag) |-> ##[0:1] !transmit_trigger;
    endproperty
    a_empty_drops_trig: assert property (p_empty_drops_trig)
        else $error("trigger stayed with empty set");
    property p_trig_drops_empty;
        $rose(transmit_trigger) |-> !transmit_empty_flag;
    endproperty
    a_trig_drops_empty: assert property (p_trig_drops_empty)
        else $error("empty stayed set after trigger");
    property p_off_no_trig;
        !transceiver_enable && $past(!transceiver_enable) |->
            !$rose(transmit_trigger);
    endproperty
    a_off_no_trig: assert property (p_off_no_trig)
        else $error("trigger taken while disabled");
    property p_int_cause;
        cascade_interrupt |-> any_event || $past(any_event);
    endproperty
    a_int_cause: assert property (p_int_cause)
        else $error("interrupt without enabled event");
endmodule
bind cslt_top cslt_top_checker u_chk (.mclk(mclk), .reset_n(reset_n),
    .cascade_serial_in(cascade_serial_in),
    .cascade_serial_out(cascade_serial_out),
    .transceiver_enable(transceiver_enable), .int_enable(int_enable),
    .transmit_trigger(transmit_trigger),
    .transmit_empty_flag(transmit_empty_flag),
    .line_reset_flag(line_reset_flag), .frame_full_flag(frame_full_flag),
    .word_full_flag(word_full_flag), .bit_timeout_flag(bit_timeout_flag),
    .bypass_enable(bypass_enable), .receive_enable(receive_enable),
    .cascade_interrupt(cascade_interrupt));

// [dv/cslt_up_model.sv]
// Upstream controller model driving pulses.
// Assumes one tick per mclk; drives on falling edges.
`timescale 1ns/100ps
module cslt_up_model #(
    parameter ONE_HIGH = 10,
    parameter ZERO_HIGH = 5,
    parameter BIT_LEN = 16
) (
    input wire mclk,
    output reg line
);
    initial line = 1'b0;
    // Hold a level n cycles; a long hold sends a line reset.
    task level(input lvl, input integer n);
        begin
            @(negedge mclk);
            line = lvl;
            repeat (n - 1) @(negedge mclk);
        end
    endtask
    // Widths clear both thresholds, so no bit is ambiguous.
    task send_bit(input b);
        begin
            level(1'b1, b ? ONE_HIGH : ZERO_HIGH);
            level(1'b0, BIT_LEN - (b ? ONE_HIGH : ZERO_HIGH));
        end
    endtask
    // First cnt bits of w, MSB first.
    task send_bits(input [23:0] w, input integer cnt);
        integer i;
        for (i = 0; i < cnt; i = i + 1) send_bit(w[23 - i]);
    endtask
endmodule

// [dv/testbench.sv]
// Self-checking bench for the transceiver top.
// Assumes one cascade tick per mclk.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin cmp_count = cmp_count + 1; \
    if ((gt) !== (ex)) begin err_count = err_count + 1; \
    $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module testbench;
    reg mclk, reset_n, transceiver_enable, transmit_mode_select;
    reg [3:0] frame_length_select;
    reg [7:0] high_threshold_count, cascade_clock_div, bit_period_count;
    reg [15:0] reset_timeout_count;
    reg [7:0] transmit_data_byte0, transmit_data_byte1, transmit_data_byte2;
    reg transmit_trigger_set, word_full_clear, bypass_clear;
    reg line_reset_send, rx_word_ready;
    reg [4:0] int_enable;
    wire cascade_serial_in, cascade_serial_out, transmit_trigger;
    wire transmit_empty_flag, line_reset_flag, frame_full_flag;
    wire word_full_flag, bit_timeout_flag, bypass_enable, receive_enable;
    wire cascade_interrupt, rx_word_valid;
    wire [23:0] rx_word;
    integer err_count, cmp_count, cycles, i, k, n;
    reg [23:0] got;
    cslt_up_model up (.mclk(mclk), .line(cascade_serial_in));
    cslt_top uut (.mclk(mclk), .reset_n(reset_n),
        .cascade_serial_in(cascade_serial_in),
        .cascade_serial_out(cascade_serial_out),
        .transceiver_enable(transceiver_enable),
        .transmit_mode_select(transmit_mode_select),
        .frame_length_select(frame_length_select),
        .high_threshold_count(high_threshold_count),
        .cascade_clock_div(cascade_clock_div),
        .bit_period_count(bit_period_count),
        .reset_timeout_count(reset_timeout_count),
        .transmit_data_byte0(transmit_data_byte0),
        .transmit_data_byte1(transmit_data_byte1),
        .transmit_data_byte2(transmit_data_byte2),
        .transmit_trigger_set(transmit_trigger_set),
        .word_full_clear(word_full_clear), .bypass_clear(bypass_clear),
        .line_reset_send(line_reset_send), .int_enable(int_enable),
        .transmit_trigger(transmit_trigger),
        .transmit_empty_flag(transmit_empty_flag),
        .line_reset_flag(line_reset_flag), .frame_full_flag(frame_full_flag),
        .word_full_flag(word_full_flag), .bit_timeout_flag(bit_timeout_flag),
        .bypass_enable(bypass_enable), .receive_enable(receive_enable),
        .cascade_interrupt(cascade_interrupt), .rx_word_valid(rx_word_valid),
        .rx_word_ready(rx_word_ready), .rx_word(rx_word));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Verdict and end of run, for main flow and watchdog.
    task complete_run;
        begin
            if (err_count == 0 && cmp_count > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    // Watchdog far above the run's few thousand cycles.
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            err_count = err_count + 1;
            complete_run;
        end
    end
    task tick(input integer c);
        repeat (c) @(negedge mclk);
    endtask
    // Line low past the 30-tick reset timeout.
    task line_reset;
        begin
            up.level(1'b0, 40);
            `CHK("line_reset", 1'b1, line_reset_flag)
            `CHK("bypass_rst", 1'b0, bypass_enable)
            `CHK("rx_en_rst", 1'b1, receive_enable)
            `CHK("timeout_rst", 1'b0, bit_timeout_flag)
            `CHK("frame_rst", 1'b0, frame_full_flag)
        end
    endtask
    // Ready is low except here, so words wait.
    task get_word(input [23:0] ex);
        begin
            for (i = 0; i < 60 && rx_word_valid !== 1'b1; i = i + 1) tick(1);
            `CHK("rx_word", ex, rx_word)
            rx_word_ready = 1'b1;
            tick(1);
            rx_word_ready = 1'b0;
        end
    endtask
    task t_receive;
        begin
            int_enable = 5'h01;
            line_reset;
            up.send_bits(24'hc35a97, 24);
            `CHK("line_reset_rise", 1'b0, line_reset_flag)
            `CHK("frame_full", 1'b1, frame_full_flag)
            `CHK("word_full", 1'b1, word_full_flag)
            `CHK("bypass_on", 1'b1, bypass_enable)
            `CHK("rx_off", 1'b0, receive_enable)
            `CHK("int_frame", 1'b1, cascade_interrupt)
            tick(5);
            `CHK("rx_held", 1'b1, rx_word_valid)
            get_word(24'hc35a97);
            up.level(1'b1, 3);
            `CHK("bypass_hi", 1'b1, cascade_serial_out)
            up.level(1'b0, 3);
            `CHK("bypass_lo", 1'b0, cascade_serial_out)
            word_full_clear = 1'b1;
            tick(1);
            word_full_clear = 1'b0;
            tick(1);
            `CHK("word_clear", 1'b0, word_full_flag)
            line_reset;
            up.send_bits(24'h3ca568, 24);
            `CHK("frame_zero", 1'b1, frame_full_flag)
            get_word(24'h3ca568);
        end
    endtask
    task t_timeouts;
        begin
            int_enable = 5'h00;
            line_reset;
            up.send_bits(24'hffffff, 3);
            up.level(1'b0, 10);
            `CHK("timeout_mid", 1'b1, bit_timeout_flag)
            `CHK("frame_mid", 1'b0, frame_full_flag)
            `CHK("int_masked", 1'b0, cascade_interrupt)
            int_enable = 5'h08;
            tick(2);
            `CHK("int_timeout", 1'b1, cascade_interrupt)
            int_enable = 5'h00;
            line_reset;
            up.send_bits(24'h000000, 23);
            up.level(1'b1, 24);
            `CHK("timeout_last", 1'b1, bit_timeout_flag)
            `CHK("frame_last", 1'b0, frame_full_flag)
            `CHK("word_last", 1'b0, word_full_flag)
            `CHK("bypass_last", 1'b0, bypass_enable)
            line_reset;
        end
    endtask
    // Two words, bytes reloaded after each empty.
    task t_transmit;
        begin
            transceiver_enable = 1'b0;
            tick(1);
            transmit_mode_select = 1'b1;
            bypass_clear = 1'b1;
            tick(1);
            bypass_clear = 1'b0;
            transceiver_enable = 1'b1;
            for (k = 0; k < 2; k = k + 1) begin
                {transmit_data_byte0, transmit_data_byte1,
                    transmit_data_byte2} = k ? 24'h5a0ff1 : 24'h963c71;
                tick(1);
                transmit_trigger_set = 1'b1;
                tick(1);
                transmit_trigger_set = 1'b0;
                tick(1);
                `CHK("trigger", 1'b1, transmit_trigger)
                `CHK("empty_low", 1'b0, transmit_empty_flag)
                `CHK("tx_path", 1'b0, bypass_enable)
                for (n = 0; n < 24; n = n + 1) begin
                    for (i = 0; i < 60 && cascade_serial_out !== 1'b1;
                        i = i + 1) tick(1);
                    for (i = 0; i < 60 && cascade_serial_out === 1'b1;
                        i = i + 1) tick(1);
                    got[23 - n] = (i > 7);
                end
                `CHK("tx_word", k ? 24'h5a0ff1 : 24'h963c71, got)
                for (i = 0; i < 60 && transmit_empty_flag !== 1'b1;
                    i = i + 1) tick(1);
                `CHK("empty_set", 1'b1, transmit_empty_flag)
                `CHK("trig_clr", 1'b0, transmit_trigger)
            end
            transceiver_enable = 1'b0;
            tick(1);
            transmit_trigger_set = 1'b1;
            tick(1);
            transmit_trigger_set = 1'b0;
            tick(2);
            `CHK("trig_off", 1'b0, transmit_trigger)
        end
    endtask
    initial begin
        {err_count, cmp_count, cycles} = 0;
        reset_n = 1'b0;
        transceiver_enable = 1'b1;
        {transmit_mode_select, frame_length_select} = 5'h00;
        {high_threshold_count, cascade_clock_div, bit_period_count}
            = 24'h070014;
        reset_timeout_count = 16'h001e;
        {transmit_data_byte0, transmit_data_byte1, transmit_data_byte2} = 0;
        {transmit_trigger_set, word_full_clear, bypass_clear,
            line_reset_send, rx_word_ready, int_enable} = 10'h000;
        tick(4);
        reset_n = 1'b1;
        tick(1);
        `CHK("empty_init", 1'b1, transmit_empty_flag)
        `CHK("rx_en_init", 1'b1, receive_enable)
        `CHK("out_init", 1'b0, cascade_serial_out)
        t_receive;
        t_timeouts;
        t_transmit;
        complete_run;
    end
endmodule
